// [logic/ctes_pkg.sv]
// Constants of the event selector
package ctes_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Counter bank shape
    localparam int N_CNT         = 4;
    localparam int L1D_CNT_LIMIT = 2;
    localparam int INC_W         = 5;
    localparam int CNT_W         = 32;
    localparam int PEND_W        = 4;
    localparam int XLAT_W        = 7;

    ////////////////////////////////////////////////////////////////////////
    // Event codes
    localparam logic [7:0] EV_LOAD_XLAT  = 8'h08;
    localparam logic [7:0] EV_DATA_XLAT  = 8'h49;
    localparam logic [7:0] EV_INSTR_XLAT = 8'h85;
    localparam logic [7:0] EV_WB         = 8'h28;
    localparam logic [7:0] EV_RD         = 8'h40;
    localparam logic [7:0] EV_ST         = 8'h41;
    localparam logic [7:0] EV_LOCK       = 8'h42;
    localparam logic [7:0] EV_REF        = 8'h43;
    localparam logic [7:0] EV_PEND       = 8'h48;
    localparam logic [7:0] EV_LINES      = 8'h51;
    localparam logic [7:0] EV_PF_LOCK_FB = 8'h52;
    localparam logic [7:0] EV_LOCK_FB    = 8'h53;
    localparam logic [7:0] EV_IFETCH     = 8'h80;
    localparam logic [7:0] EV_STREAM     = 8'h83;
    localparam logic [7:0] EV_DPF        = 8'h4E;

    // Unit-mask bits of the outstanding miss event
    localparam int UMB_PEND    = 0;
    localparam int UMB_FB_FULL = 1;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [7:0] REG_SEL_OFS = 8'h00;
    localparam logic [7:0] REG_CNT_OFS = 8'h04;
    localparam logic [7:0] REG_STRIDE  = 8'h10;
    localparam logic [7:0] REG_STAT    = 8'h40;
    localparam logic [7:0] REG_CTRL    = 8'h44;

    // Field positions
    localparam int SEL_CODE_LSB = 0;
    localparam int SEL_MASK_LSB = 8;
    localparam int SEL_EN_BIT   = 16;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int STAT_BLK_LSB = 0;
    localparam int STAT_ACT_LSB = 4;

    // Reset values
    localparam logic [7:0]       CODE_RST = 8'h00;
    localparam logic [7:0]       MASK_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST  = 32'h0000_0000;
    localparam logic             RUN_RST  = 1'b1;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [logic/ctes_occ_if.sv]
// Occurrence reports from the selector top to its decoders
`timescale 1ns/1ps
`default_nettype none
interface ctes_occ_if;
    logic [6:0] xlat_load;
    logic [6:0] xlat_store;
    logic [6:0] xlat_instr;
    logic       wb_vld;
    logic [1:0] wb_state;
    logic       rd_vld;
    logic [1:0] rd_state;
    logic       st_vld;
    logic [1:0] st_state;
    logic       lock_vld;
    logic [1:0] lock_state;
    logic       ref_vld;
    logic       ref_cacheable;
    logic [3:0] pend_cnt;
    logic       fb_full;
    logic [2:0] lines;
    logic       pf_lock_fb;
    logic       lock_fb;
    logic [2:0] ifetch;
    logic       stream_hit;
    logic [2:0] dpf;
    modport src (output xlat_load, xlat_store, xlat_instr, wb_vld, wb_state, rd_vld, rd_state,
                 st_vld, st_state, lock_vld, lock_state, ref_vld, ref_cacheable, pend_cnt,
                 fb_full, lines, pf_lock_fb, lock_fb, ifetch, stream_hit, dpf);
    modport sink (input xlat_load, xlat_store, xlat_instr, wb_vld, wb_state, rd_vld, rd_state,
                  st_vld, st_state, lock_vld, lock_state, ref_vld, ref_cacheable, pend_cnt,
                  fb_full, lines, pf_lock_fb, lock_fb, ifetch, stream_hit, dpf);
endinterface
`default_nettype wire

// [logic/ctes_decode.sv]
// Per-counter decoder: event code and unit mask to an increment
`timescale 1ns/1ps
`default_nettype none
module ctes_decode (
    // Selection
    input  wire logic [7:0]                code,
    input  wire logic [7:0]                umask,
    // Occurrences
    ctes_occ_if.sink                       occ,
    // Result
    output logic [ctes_pkg::INC_W-1:0]     inc,
    output logic                           is_l1d
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [3:0] popc(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int b = 0; b < 8; b++) begin
            n = n + {3'h0, v[b]};
        end
        return n;
    endfunction

    // Translation bits sit at mask bits 0,1,3..7; bit 2 is unused
    function automatic logic [7:0] xmap(input logic [6:0] v);
        return {v[6:2], 1'b0, v[1:0]};
    endfunction

    // State to one-hot I,S,E,M; an I-state reference is a miss
    function automatic logic [3:0] soh(input logic vld, input logic [1:0] s);
        return vld ? (4'h1 << s) : 4'h0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Event vector select and count of selected occurrences
    always_comb begin
        logic [7:0] vec;
        logic [4:0] sum;
        logic [3:0] lk;
        vec = 8'h00;
        sum = 5'h00;
        lk = soh(occ.lock_vld, occ.lock_state);
        is_l1d = 1'b0;
        case (code)
            ctes_pkg::EV_LOAD_XLAT: vec = xmap(occ.xlat_load);
            ctes_pkg::EV_DATA_XLAT: begin
                sum = {1'b0, popc(umask & xmap(occ.xlat_store))};
                vec = xmap(occ.xlat_load);
            end
            ctes_pkg::EV_INSTR_XLAT: vec = xmap(occ.xlat_instr);
            ctes_pkg::EV_WB: begin
                vec = {4'h0, soh(occ.wb_vld, occ.wb_state)};
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_RD: begin
                vec = {4'h0, soh(occ.rd_vld, occ.rd_state)};
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_ST: begin
                vec = {4'h0, soh(occ.st_vld, occ.st_state)};
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_LOCK: begin
                vec = {4'h0, lk[3:1], occ.lock_vld & ~lk[0]};
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_REF: begin
                vec = {6'h00, occ.ref_vld & occ.ref_cacheable, occ.ref_vld};
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_PEND: begin
                if (umask[ctes_pkg::UMB_PEND]) begin
                    sum = {1'b0, occ.pend_cnt};
                end
                vec[ctes_pkg::UMB_FB_FULL] = occ.fb_full;
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_LINES: begin
                vec = {4'h0, occ.lines[2], 1'b0, occ.lines[1:0]};
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_PF_LOCK_FB: begin
                vec = {7'h00, occ.pf_lock_fb};
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_LOCK_FB: begin
                vec = {7'h00, occ.lock_fb};
                is_l1d = 1'b1;
            end
            ctes_pkg::EV_IFETCH: vec = {5'h00, occ.ifetch[2], occ.ifetch[1:0]};
            ctes_pkg::EV_STREAM: vec = {7'h00, occ.stream_hit};
            ctes_pkg::EV_DPF: begin
                vec = {5'h00, occ.dpf};
                is_l1d = 1'b1;
            end
            default: vec = 8'h00;
        endcase
        inc = sum + {1'b0, popc(umask & vec)};
    end

endmodule
`default_nettype wire

// [logic/ctes_top.sv]
// Event selector with four counters on AXI4-Lite
//
// Overview of operation
// - Data cache events count on counters 0 and 1 only.
// - Code 08 counts load translation misses, masks 01,02,08,10,20,40,80.
// - Code 49 counts load and store translation misses, same variants.
// - Code 85 counts instruction translation misses, same variants.
// - Code 28 counts writebacks by second-level state, 01/02/04/08 I/S/E/M, 0F all.
// - Code 40 counts reads by line state, 01/02/04/08 I/S/E/M, 0F all.
// - Code 41 counts stores by line state, 01/02/04/08 I/S/E/M, 0F all.
// - An invalid-state reference counts as a miss (01) in the splits of codes 28/40/41; code 42 counts it under no mask.
// - Code 42 counts locked loads, 01 hits, 02/04/08 S/E/M lines.
// - Code 43 counts data references, 01 all, 02 cacheable only.
// - Code 48 adds outstanding misses per cycle (01), counts fill-buffer-full cycles (02).
// - Code 51 counts lines allocated (01), allocated modified (02), snoop M evictions (08).
// - Codes 52/53, mask 01, count prefetch locked and locked loads taken by the fill buffer.
// - Code 80 counts fetch hits (01), misses (02), all (03), stalls (04).
// - Code 83 with mask 01 counts opportunistic hits from the streaming buffer.
// - Code 4E counts data prefetch requests (01), misses (02), state machine triggers (04).
`timescale 1ns/1ps
`default_nettype none
module ctes_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Translation occurrences: any, walk, busy, hit2, low, high, large
    input  wire logic [6:0]  xlat_load_evt,
    input  wire logic [6:0]  xlat_store_evt,
    input  wire logic [6:0]  xlat_instr_evt,
    // Data cache writebacks, reads, stores, locked loads
    input  wire logic        wb_vld,
    input  wire logic [1:0]  wb_state,
    input  wire logic        rd_vld,
    input  wire logic [1:0]  rd_state,
    input  wire logic        st_vld,
    input  wire logic [1:0]  st_state,
    input  wire logic        lock_vld,
    input  wire logic [1:0]  lock_state,
    // Data cache references and misses
    input  wire logic        ref_vld,
    input  wire logic        ref_cacheable,
    input  wire logic [3:0]  pend_miss_cnt,
    input  wire logic        load_fb_full,
    // Line allocation and fill buffer
    input  wire logic        line_alloc,
    input  wire logic        line_alloc_mod,
    input  wire logic        snoop_evict_mod,
    input  wire logic        pf_lock_fb_acc,
    input  wire logic        lock_fb_acc,
    // Instruction side
    input  wire logic        fetch_hit,
    input  wire logic        fetch_miss,
    input  wire logic        fetch_stall,
    input  wire logic        stream_buf_hit,
    // Data prefetcher
    input  wire logic        dpf_request,
    input  wire logic        dpf_miss,
    input  wire logic        dpf_trigger,
    // Counter values for the bank
    output logic [31:0]      cnt_val_0,
    output logic [31:0]      cnt_val_1,
    output logic [31:0]      cnt_val_2,
    output logic [31:0]      cnt_val_3
);

    localparam int N = ctes_pkg::N_CNT;
    localparam int CW = ctes_pkg::CNT_W;
    localparam int IW = ctes_pkg::INC_W;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [N-1:0][7:0]    code;
        logic [N-1:0][7:0]    umask;
        logic [N-1:0]         en;
        logic [N-1:0][CW-1:0] cnt;
        logic                 run;
        logic                 aw_got;
        logic                 w_got;
        logic [7:0]           awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } ctes_state_t;

    ctes_state_t st_r;
    ctes_state_t st_nxt;

    logic [IW-1:0] inc    [N];
    logic          is_l1d [N];
    logic [N-1:0]  blk;
    logic [N-1:0]  act;

    ////////////////////////////////////////////////////////////////////////
    // Occurrences into the shared carrier
    ctes_occ_if occ ();

    assign occ.xlat_load     = xlat_load_evt;
    assign occ.xlat_store    = xlat_store_evt;
    assign occ.xlat_instr    = xlat_instr_evt;
    assign occ.wb_vld        = wb_vld;
    assign occ.wb_state      = wb_state;
    assign occ.rd_vld        = rd_vld;
    assign occ.rd_state      = rd_state;
    assign occ.st_vld        = st_vld;
    assign occ.st_state      = st_state;
    assign occ.lock_vld      = lock_vld;
    assign occ.lock_state    = lock_state;
    assign occ.ref_vld       = ref_vld;
    assign occ.ref_cacheable = ref_cacheable;
    assign occ.pend_cnt      = pend_miss_cnt;
    assign occ.fb_full       = load_fb_full;
    assign occ.lines         = {snoop_evict_mod, line_alloc_mod, line_alloc};
    assign occ.pf_lock_fb    = pf_lock_fb_acc;
    assign occ.lock_fb       = lock_fb_acc;
    assign occ.ifetch        = {fetch_stall, fetch_miss, fetch_hit};
    assign occ.stream_hit    = stream_buf_hit;
    assign occ.dpf           = {dpf_trigger, dpf_miss, dpf_request};

    ////////////////////////////////////////////////////////////////////////
    // One decoder per counter, data cache gate on upper pair
    for (genvar g = 0; g < N; g++) begin : g_cnt
        ctes_decode u_dec (
            .code   (st_r.code[g]),
            .umask  (st_r.umask[g]),
            .occ    (occ),
            .inc    (inc[g]),
            .is_l1d (is_l1d[g])
        );
        assign blk[g] = is_l1d[g] && (g >= ctes_pkg::L1D_CNT_LIMIT);
        assign act[g] = st_r.run && st_r.en[g] && !blk[g] && (inc[g] != '0);
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshakes
    assign awready = !st_r.aw_got && !st_r.bvalid;
    assign wready  = !st_r.w_got && !st_r.bvalid;
    assign arready = !st_r.rvalid;
    assign bvalid  = st_r.bvalid;
    assign bresp   = st_r.bresp;
    assign rvalid  = st_r.rvalid;
    assign rdata   = st_r.rdata;
    assign rresp   = st_r.rresp;

    // Counter values out
    assign cnt_val_0 = st_r.cnt[0];
    assign cnt_val_1 = st_r.cnt[1];
    assign cnt_val_2 = st_r.cnt[2];
    assign cnt_val_3 = st_r.cnt[3];

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane write merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] w;
        w = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                w[8*b +: 8] = d[8*b +: 8];
            end
        end
        return w;
    endfunction

    // Selection register word of counter i
    function automatic logic [31:0] sel_word(input ctes_state_t s, input int i);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ctes_pkg::SEL_CODE_LSB +: 8] = s.code[i];
        w[ctes_pkg::SEL_MASK_LSB +: 8] = s.umask[i];
        w[ctes_pkg::SEL_EN_BIT] = s.en[i];
        return w;
    endfunction

    // Register addresses of counter i
    function automatic logic [7:0] sel_addr(input int i);
        return 8'(ctes_pkg::REG_SEL_OFS + ctes_pkg::REG_STRIDE * i);
    endfunction

    function automatic logic [7:0] cnt_addr(input int i);
        return 8'(ctes_pkg::REG_CNT_OFS + ctes_pkg::REG_STRIDE * i);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state: counting, register writes, register reads
    always_comb begin
        logic [7:0]  wa;
        logic [7:0]  ra;
        logic [31:0] w;
        logic [31:0] rd;
        logic        hit;
        st_nxt = st_r;
        wa = {st_r.awaddr[7:2], 2'h0};
        ra = {araddr[7:2], 2'h0};
        w = 32'h0000_0000;
        rd = 32'h0000_0000;
        hit = 1'b0;

        // Counting by matching occurrences
        for (int i = 0; i < N; i++) begin
            if (act[i]) begin
                st_nxt.cnt[i] = st_r.cnt[i] + CW'(inc[i]);
            end
        end

        // Write address and data taken in either order
        if (awvalid && awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end

        // Write once both halves are held; software beats counting
        if (st_r.aw_got && st_r.w_got) begin
            for (int i = 0; i < N; i++) begin
                if (wa == sel_addr(i)) begin
                    w = merge(sel_word(st_r, i), st_r.wdata, st_r.wstrb);
                    st_nxt.code[i] = w[ctes_pkg::SEL_CODE_LSB +: 8];
                    st_nxt.umask[i] = w[ctes_pkg::SEL_MASK_LSB +: 8];
                    st_nxt.en[i] = w[ctes_pkg::SEL_EN_BIT];
                    hit = 1'b1;
                end
                if (wa == cnt_addr(i)) begin
                    st_nxt.cnt[i] = merge(st_r.cnt[i], st_r.wdata, st_r.wstrb);
                    hit = 1'b1;
                end
            end
            if (wa == ctes_pkg::REG_CTRL) begin
                if (st_r.wstrb[0]) begin
                    st_nxt.run = st_r.wdata[ctes_pkg::CTRL_RUN_BIT];
                    if (st_r.wdata[ctes_pkg::CTRL_CLR_BIT]) begin
                        st_nxt.cnt = '0;
                    end
                end
                hit = 1'b1;
            end
            if (wa == ctes_pkg::REG_STAT) begin
                hit = 1'b1;
            end
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = hit ? ctes_pkg::RESP_OKAY : ctes_pkg::RESP_SLVERR;
        end else if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read answered the cycle after the address
        if (arvalid && arready) begin
            hit = 1'b0;
            for (int i = 0; i < N; i++) begin
                if (ra == sel_addr(i)) begin
                    rd = sel_word(st_r, i);
                    hit = 1'b1;
                end
                if (ra == cnt_addr(i)) begin
                    rd = st_r.cnt[i];
                    hit = 1'b1;
                end
            end
            if (ra == ctes_pkg::REG_STAT) begin
                rd[ctes_pkg::STAT_BLK_LSB +: N] = blk;
                rd[ctes_pkg::STAT_ACT_LSB +: N] = act;
                hit = 1'b1;
            end
            if (ra == ctes_pkg::REG_CTRL) begin
                rd[ctes_pkg::CTRL_RUN_BIT] = st_r.run;
                hit = 1'b1;
            end
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd;
            st_nxt.rresp = hit ? ctes_pkg::RESP_OKAY : ctes_pkg::RESP_SLVERR;
        end else if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, synchronous reset clears the selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.code <= {N{ctes_pkg::CODE_RST}};
            st_r.umask <= {N{ctes_pkg::MASK_RST}};
            st_r.cnt <= {N{ctes_pkg::CNT_RST}};
            st_r.run <= ctes_pkg::RUN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule
`default_nettype wire

// [tb/ctes_top_asserts.sv]
// Bus and reset checks for the event selector
`timescale 1ns/1ps
`default_nettype none
module ctes_top_asserts (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    // Counter value
    input wire logic [31:0] cnt_val_0
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // Write channel
    property p_b_ans; awvalid && awready && wvalid && wready |=> ##1 bvalid; endproperty
    a_b_ans: assert property (p_b_ans) else $error("b late");
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("b dropped");
    property p_b_busy; bvalid |-> !awready && !wready; endproperty
    a_b_busy: assert property (p_b_busy) else $error("write in b");
    property p_b_free; bvalid && bready |=> !bvalid && awready && wready; endproperty
    a_b_free: assert property (p_b_free) else $error("b not freed");
    ////////////////////////////////////////////////////////////////////////
    // Read channel
    property p_r_ans; arvalid && arready |=> rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("r late");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("r dropped");
    property p_r_free; rvalid && rready |=> !rvalid && arready; endproperty
    a_r_free: assert property (p_r_free) else $error("r not freed");
    // Reset state
    property p_rst; $rose(aresetn) |-> cnt_val_0 == 32'h0 && !bvalid && !rvalid; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
`default_nettype wire

// [tb/ctes_core_model.sv]
// Core-side occurrence source, one chosen occurrence per cycle
`timescale 1ns/1ps
`default_nettype none
module ctes_core_model (
    // Clock and bench control
    input  wire logic        aclk,
    input  wire logic        go,
    input  wire logic [5:0]  sel,
    input  wire logic [1:0]  st,
    // One-hot occurrences and line state
    output logic      [40:0] occ,
    output logic      [1:0]  state
);
    initial state = 2'h0;
    // Idle state toggles, never stale
    always @(posedge aclk) begin
        occ   <= go ? (41'h1 << sel) : 41'h0;
        state <= go ? st : ~state;
    end
endmodule
`default_nettype wire

// [tb/tb_cache_tlb_event_select.sv]
// Self-checking bench for the event selector
`timescale 1ns/1ps
`default_nettype none
module tb_cache_tlb_event_select;
    logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, cnt_val_0, cnt_val_1, cnt_val_2, cnt_val_3;
    logic [3:0]  wstrb = 4'hF, pend_miss_cnt;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, st = 2'h0, state, wb_state, rd_state, st_state, lock_state;
    logic [5:0]  sel = 6'h00;
    logic [40:0] occ;
    logic [6:0]  xlat_load_evt, xlat_store_evt, xlat_instr_evt;
    logic        wb_vld, rd_vld, st_vld, lock_vld, ref_vld, ref_cacheable, load_fb_full, line_alloc;
    logic        line_alloc_mod, snoop_evict_mod, pf_lock_fb_acc, lock_fb_acc, fetch_hit, fetch_miss;
    logic        fetch_stall, stream_buf_hit, dpf_request, dpf_miss, dpf_trigger;
    int          n_fail = 0, num_checks = 0;
    // Rows: counter, code, mask, occurrence, state, expected count
    logic [35:0] rows [34] = '{
        36'h0_28_01_15_0_3, 36'h0_28_08_15_3_3, 36'h0_28_0F_15_2_3, 36'h0_28_02_15_0_0,
        36'h1_40_01_16_0_3, 36'h1_40_04_16_2_3, 36'h1_40_0F_16_1_3,
        36'h0_41_08_17_3_3, 36'h0_41_02_17_3_0,
        36'h0_42_01_18_1_3, 36'h0_42_01_18_0_0, 36'h0_42_08_18_3_3,
        36'h0_43_01_1A_0_3, 36'h0_43_02_1A_0_0, 36'h1_43_02_19_0_3,
        36'h0_48_01_1B_0_9, 36'h0_48_02_1C_0_3,
        36'h0_51_01_1D_0_3, 36'h0_51_02_1E_0_3, 36'h0_51_08_1F_0_3,
        36'h0_52_01_20_0_3, 36'h0_53_01_21_0_3,
        36'h0_80_01_22_0_3, 36'h0_80_02_23_0_3, 36'h0_80_03_23_0_3, 36'h0_80_04_24_0_3,
        36'h0_83_01_25_0_3,
        36'h1_4E_01_26_0_3, 36'h1_4E_02_27_0_3, 36'h1_4E_04_28_0_3,
        36'h2_40_0F_16_0_0, 36'h3_28_0F_15_0_0, 36'h3_4E_01_26_0_0, 36'h2_80_01_22_0_3};
    ////////////////////////////////////////////////////////////////////////
    // Occurrence vector onto core ports
    assign {xlat_instr_evt, xlat_store_evt, xlat_load_evt} = occ[20:0];
    assign {lock_vld, st_vld, rd_vld, wb_vld} = occ[24:21];
    assign {wb_state, rd_state, st_state, lock_state} = {4{state}};
    assign ref_vld = occ[25] | occ[26];
    assign ref_cacheable = occ[25];
    assign pend_miss_cnt = occ[27] ? 4'h3 : 4'h0;
    assign {dpf_trigger, dpf_miss, dpf_request, stream_buf_hit, fetch_stall, fetch_miss, fetch_hit, lock_fb_acc,
            pf_lock_fb_acc, snoop_evict_mod, line_alloc_mod, line_alloc, load_fb_full} = occ[40:28];
    ctes_top i_dut (.*);
    ctes_core_model i_core (.*);
    always #2.5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////
    // Compare, verdict and bus tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] p;
        p = 2'h3;
        @(posedge aclk);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        wdata <= d;
        while (p != 2'h0) begin
            @(posedge aclk);
            if (awready === 1'b1) p[1] = 1'b0;
            if (wready === 1'b1) p[0] = 1'b0;
            {awvalid, wvalid} <= p;
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        chk("bresp", 32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        chk(nm, rdata, e);
        chk("rresp", 32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask
    // Clear, select, three occurrences, read back
    task automatic run(input logic [35:0] r);
        wr(ctes_pkg::REG_CTRL, 32'h0000_0003, ctes_pkg::RESP_OKAY);
        wr({2'h0, r[33:32], 4'h0}, {15'h0000, 1'b1, r[23:16], r[31:24]}, ctes_pkg::RESP_OKAY);
        st <= r[5:4];
        sel <= r[13:8];
        go <= 1'b1;
        repeat (3) @(posedge aclk);
        go <= 1'b0;
        repeat (3) @(posedge aclk);
        rdc("count", {2'h0, r[33:32], 4'h4}, 32'(r[3:0]), ctes_pkg::RESP_OKAY);
        chk("port", r[33] ? (r[32] ? cnt_val_3 : cnt_val_2) : (r[32] ? cnt_val_1 : cnt_val_0), 32'(r[3:0]));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] cd, mk, sl;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdc("sel0", 8'h00, 32'h0, ctes_pkg::RESP_OKAY);
        rdc("cnt3", 8'h34, 32'h0, ctes_pkg::RESP_OKAY);
        rdc("ctrl", 8'h44, 32'h1, ctes_pkg::RESP_OKAY);
        rdc("hole", 8'h48, 32'h0, ctes_pkg::RESP_SLVERR);
        wr(8'h4C, 32'h1, ctes_pkg::RESP_SLVERR);
        for (int i = 0; i < 34; i++) run(rows[i]);
        chk("cnt2 port", cnt_val_2, 32'h3);
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 7; j++) begin
                cd = (k == 0) ? 8'h08 : (k == 3) ? 8'h85 : 8'h49;
                mk = 8'h01 << (j + (j > 1));
                sl = 8'(j + 7 * (k - (k > 0)));
                run({k[3:0], cd, mk, sl, 8'h03});
            end
        end
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("cnt3 reset", cnt_val_3, 32'h0);
        run(36'h0_08_01_07_0_0);
        print_verdict();
    end
    // Watchdog
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
endmodule
bind ctes_top ctes_top_asserts i_chk (.*);
`default_nettype wire
